// [src/trigger_crossbar_consts.vh]
// constants for the trigger crossbar selector registers
//
// Behaviour
// - Selector registers are accessed only as whole aligned 32-bit words.
// - Bit 31 lock is set by writing one; only system reset clears it.
// - First external register: four 7-bit fields at 6:0,14:8,22:16,30:24 for outputs 0-3.
// - Second external register: same layout, fields select external outputs 4 through 7.
// - ADC0 register: one 7-bit field at 6:0 feeds ADC0 routine trigger; 30:7 reserved.
// - Both external registers reset to all zeros, lock clear.
// - ADC0 register resets to 0x00001E16, lock clear.
// - Registers decode at offsets 0x00, 0x04, 0x08 from base 0x40018400.
// - Select value 0 routes constant low, value 1 routes constant high.
`ifndef TRIGGER_CROSSBAR_CONSTS_VH
`define TRIGGER_CROSSBAR_CONSTS_VH

`define TSEL_BASE_ADDR 32'h40018400
`define TSEL_ADDR_W 8
`define TSEL_OFF_EXT_LOW 8'h00
`define TSEL_OFF_EXT_HIGH 8'h04
`define TSEL_OFF_ADC0 8'h08

`define TSEL_DATA_W 32
`define TSEL_SEL_W 7
`define TSEL_SRC_COUNT 128
`define TSEL_EXT_SRC_W 126
`define TSEL_OUT_COUNT 9
`define TSEL_EXT_OUT_COUNT 8
`define TSEL_ADC0_OUT_IDX 8
`define TSEL_LOCK_COUNT 3
`define TSEL_LOCK_BIT 31
`define TSEL_F0_LSB 0
`define TSEL_F1_LSB 8
`define TSEL_F2_LSB 16
`define TSEL_F3_LSB 24

`define TSEL_SEL_CONST_LOW 7'h00
`define TSEL_SEL_CONST_HIGH 7'h01

`define TSEL_EXT_RESET 32'h00000000
`define TSEL_ADC0_RESET 32'h00001E16
`define TSEL_ADC0_FIELD_RESET 7'h16
`define TSEL_ADC0_RSVD_MASK 32'h7FFFFF80

`endif

// [src/trigger_route_mux.v]
// one routing selector: picks a source line by a 7-bit select code
`timescale 1ns/1ps
`default_nettype none
`include "trigger_crossbar_consts.vh"

module trigger_route_mux (
  input wire [`TSEL_SRC_COUNT-1:0] sourceVector,
  input wire [`TSEL_SEL_W-1:0] select,
  output wire routed
);

  // pure index; codes 0 and 1 land on the tied low and high entries
  assign routed = sourceVector[select];

endmodule
`default_nettype wire

// [src/trigger_source_select_regs.v]
// selector registers and routing for external outputs 0-7 and the ADC0 routine trigger
`timescale 1ns/1ps
`default_nettype none
`include "trigger_crossbar_consts.vh"

module trigger_source_select_regs (
  input wire clock,
  input wire srst,
  input wire [`TSEL_ADDR_W-1:0] address,
  input wire [`TSEL_DATA_W-1:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  output reg [`TSEL_DATA_W-1:0] readData,
  input wire [`TSEL_EXT_SRC_W-1:0] triggerSources,
  output reg [7:0] extTriggerOut,
  output reg adc0RoutineTrigger,
  output reg [2:0] lockState
);

  // selector storage, one flip-flop group per field
  reg [`TSEL_SEL_W-1:0] extSel_reg [0:7];
  reg [`TSEL_SEL_W-1:0] adc0Sel_reg;
  reg extLowLock_reg;
  reg extHighLock_reg;
  reg adc0Lock_reg;

  // reset words held as vectors, since a field cannot be sliced from a bare literal
  localparam [`TSEL_DATA_W-1:0] EXT_RESET_WORD = `TSEL_EXT_RESET;
  localparam [`TSEL_DATA_W-1:0] ADC0_RESET_WORD = `TSEL_ADC0_RESET;
  localparam [`TSEL_DATA_W-1:0] ADC0_RSVD_MASK = `TSEL_ADC0_RSVD_MASK;
  localparam [`TSEL_SEL_W-1:0] EXT_F0_RESET = EXT_RESET_WORD[`TSEL_F0_LSB +: `TSEL_SEL_W];
  localparam [`TSEL_SEL_W-1:0] EXT_F1_RESET = EXT_RESET_WORD[`TSEL_F1_LSB +: `TSEL_SEL_W];
  localparam [`TSEL_SEL_W-1:0] EXT_F2_RESET = EXT_RESET_WORD[`TSEL_F2_LSB +: `TSEL_SEL_W];
  localparam [`TSEL_SEL_W-1:0] EXT_F3_RESET = EXT_RESET_WORD[`TSEL_F3_LSB +: `TSEL_SEL_W];
  localparam [`TSEL_SEL_W-1:0] ADC0_F0_RESET = ADC0_RESET_WORD[`TSEL_F0_LSB +: `TSEL_SEL_W];
  localparam [0:0] EXT_LOCK_RESET = EXT_RESET_WORD[`TSEL_LOCK_BIT];
  localparam [0:0] ADC0_LOCK_RESET = ADC0_RESET_WORD[`TSEL_LOCK_BIT];
  localparam [`TSEL_DATA_W-1:0] ADC0_RSVD_READ = ADC0_RESET_WORD & ADC0_RSVD_MASK;
  localparam [`TSEL_EXT_OUT_COUNT-1:0] EXT_OUT_RESET = {`TSEL_EXT_OUT_COUNT{1'b0}};
  localparam [0:0] ADC0_OUT_RESET = 1'b0;
  localparam [`TSEL_LOCK_COUNT-1:0] LOCK_STATE_RESET = {`TSEL_LOCK_COUNT{1'b0}};

  // decode
  wire hitExtLow;
  wire hitExtHigh;
  wire hitAdc0;
  wire anyHit;
  wire writeExtLow;
  wire writeExtHigh;
  wire writeAdc0;

  // full-address compare: any misaligned address misses every register
  assign hitExtLow = (address == `TSEL_OFF_EXT_LOW);
  assign hitExtHigh = (address == `TSEL_OFF_EXT_HIGH);
  assign hitAdc0 = (address == `TSEL_OFF_ADC0);
  assign anyHit = hitExtLow | hitExtHigh | hitAdc0;

  // a locked register swallows the write, lock bit included
  assign writeExtLow = writeStrobe & hitExtLow & ~extLowLock_reg;
  assign writeExtHigh = writeStrobe & hitExtHigh & ~extHighLock_reg;
  assign writeAdc0 = writeStrobe & hitAdc0 & ~adc0Lock_reg;

  // lock next values: once set only reset reaches the flop, so a write of zero cannot clear it
  wire extLowLock_next;
  wire extHighLock_next;
  wire adc0Lock_next;

  assign extLowLock_next = extLowLock_reg | (writeExtLow & writeData[`TSEL_LOCK_BIT]);
  assign extHighLock_next = extHighLock_reg | (writeExtHigh & writeData[`TSEL_LOCK_BIT]);
  assign adc0Lock_next = adc0Lock_reg | (writeAdc0 & writeData[`TSEL_LOCK_BIT]);

  // field extraction from the write word, same layout for both external registers
  wire [`TSEL_SEL_W-1:0] wrField0;
  wire [`TSEL_SEL_W-1:0] wrField1;
  wire [`TSEL_SEL_W-1:0] wrField2;
  wire [`TSEL_SEL_W-1:0] wrField3;

  assign wrField0 = writeData[`TSEL_F0_LSB +: `TSEL_SEL_W];
  assign wrField1 = writeData[`TSEL_F1_LSB +: `TSEL_SEL_W];
  assign wrField2 = writeData[`TSEL_F2_LSB +: `TSEL_SEL_W];
  assign wrField3 = writeData[`TSEL_F3_LSB +: `TSEL_SEL_W];

  // first external register: outputs 0..3
  always @(posedge clock) begin
    if (srst) begin
      extSel_reg[0] <= EXT_F0_RESET;
      extSel_reg[1] <= EXT_F1_RESET;
      extSel_reg[2] <= EXT_F2_RESET;
      extSel_reg[3] <= EXT_F3_RESET;
      extLowLock_reg <= EXT_LOCK_RESET;
    end else begin
      if (writeExtLow) begin
        extSel_reg[0] <= wrField0;
        extSel_reg[1] <= wrField1;
        extSel_reg[2] <= wrField2;
        extSel_reg[3] <= wrField3;
      end
      extLowLock_reg <= extLowLock_next;
    end
  end

  // second external register: outputs 4..7
  always @(posedge clock) begin
    if (srst) begin
      extSel_reg[4] <= EXT_F0_RESET;
      extSel_reg[5] <= EXT_F1_RESET;
      extSel_reg[6] <= EXT_F2_RESET;
      extSel_reg[7] <= EXT_F3_RESET;
      extHighLock_reg <= EXT_LOCK_RESET;
    end else begin
      if (writeExtHigh) begin
        extSel_reg[4] <= wrField0;
        extSel_reg[5] <= wrField1;
        extSel_reg[6] <= wrField2;
        extSel_reg[7] <= wrField3;
      end
      extHighLock_reg <= extHighLock_next;
    end
  end

  // ADC0 register: single field, reserved bits held at their reset pattern
  always @(posedge clock) begin
    if (srst) begin
      adc0Sel_reg <= ADC0_F0_RESET;
      adc0Lock_reg <= ADC0_LOCK_RESET;
    end else begin
      if (writeAdc0) begin
        adc0Sel_reg <= wrField0;
      end
      adc0Lock_reg <= adc0Lock_next;
    end
  end

  // read-back words; reserved bits are not stored, they read as reset value
  wire [`TSEL_DATA_W-1:0] extLowWord;
  wire [`TSEL_DATA_W-1:0] extHighWord;
  wire [`TSEL_DATA_W-1:0] adc0Word;

  assign extLowWord = {extLowLock_reg, extSel_reg[3], 1'b0, extSel_reg[2],
                       1'b0, extSel_reg[1], 1'b0, extSel_reg[0]};
  assign extHighWord = {extHighLock_reg, extSel_reg[7], 1'b0, extSel_reg[6],
                        1'b0, extSel_reg[5], 1'b0, extSel_reg[4]};
  // the reserved pattern is nonzero here; it is ORed into the read word and writes to those bits are ignored
  assign adc0Word = ADC0_RSVD_READ | {adc0Lock_reg, 24'h000000, adc0Sel_reg};

  reg [`TSEL_DATA_W-1:0] readData_next;
  wire readEnable;

  // unmapped and misaligned reads fall through to the zero word
  assign readEnable = readStrobe & anyHit;

  always @* begin
    readData_next = {`TSEL_DATA_W{1'b0}};
    if (readEnable) begin
      case (1'b1)
        hitExtLow: begin
          readData_next = extLowWord;
        end
        hitExtHigh: begin
          readData_next = extHighWord;
        end
        hitAdc0: begin
          readData_next = adc0Word;
        end
        default: begin
          readData_next = {`TSEL_DATA_W{1'b0}};
        end
      endcase
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always @(posedge clock) begin
    if (srst) begin
      readData <= {`TSEL_DATA_W{1'b0}};
    end else begin
      readData <= readData_next;
    end
  end

  // routing: two fixed levels below the external sources form the source table
  wire [`TSEL_SRC_COUNT-1:0] sourceVector;
  wire [`TSEL_OUT_COUNT*`TSEL_SEL_W-1:0] selectFlat;
  wire [`TSEL_OUT_COUNT-1:0] routedNext;

  assign sourceVector = {triggerSources, 1'b1, 1'b0};
  assign selectFlat = {adc0Sel_reg, extSel_reg[7], extSel_reg[6], extSel_reg[5],
                       extSel_reg[4], extSel_reg[3], extSel_reg[2], extSel_reg[1],
                       extSel_reg[0]};

  genvar outIdx;
  generate
    for (outIdx = 0; outIdx < `TSEL_OUT_COUNT; outIdx = outIdx + 1) begin : routeGen
      trigger_route_mux routeMux (
        .sourceVector(sourceVector),
        .select(selectFlat[outIdx*`TSEL_SEL_W +: `TSEL_SEL_W]),
        .routed(routedNext[outIdx])
      );
    end
  endgenerate

  // output stage next values, split out so each output flop has one plain source
  wire [`TSEL_EXT_OUT_COUNT-1:0] extTriggerOut_next;
  wire adc0RoutineTrigger_next;
  wire [`TSEL_LOCK_COUNT-1:0] lockState_next;

  assign extTriggerOut_next = routedNext[`TSEL_EXT_OUT_COUNT-1:0];
  assign adc0RoutineTrigger_next = routedNext[`TSEL_ADC0_OUT_IDX];
  assign lockState_next = {adc0Lock_reg, extHighLock_reg, extLowLock_reg};

  // outputs are registered for a clean launch; this costs one cycle of latency
  always @(posedge clock) begin
    if (srst) begin
      extTriggerOut <= EXT_OUT_RESET;
      adc0RoutineTrigger <= ADC0_OUT_RESET;
      lockState <= LOCK_STATE_RESET;
    end else begin
      extTriggerOut <= extTriggerOut_next;
      adc0RoutineTrigger <= adc0RoutineTrigger_next;
      lockState <= lockState_next;
    end
  end

endmodule
`default_nettype wire

// [tb/trigger_source_select_regs_monitor.sv]
// assertion checker for the trigger selector registers
`timescale 1ns/1ps
`default_nettype none
module trigger_source_select_regs_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] address,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [31:0] readData,
  input wire logic [7:0] extTriggerOut,
  input wire logic adc0RoutineTrigger,
  input wire logic [2:0] lockState
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_rst; disable iff (1'b0) srst |=> readData == 32'h0 && extTriggerOut == 8'h00
    && !adc0RoutineTrigger && lockState == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_idle; !readStrobe |=> readData == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_unmap; readStrobe && address != 8'h00 && address != 8'h04 && address != 8'h08
    |=> readData == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ext_rsvd; readStrobe && (address == 8'h00 || address == 8'h04)
    |=> (readData & 32'h00808080) == 32'h0; endproperty
  a_ext_rsvd: assert property (p_ext_rsvd) else $error("ext reserved bits set");
  property p_adc_rsvd; readStrobe && address == 8'h08 |=> readData[30:7] == 24'h00003C; endproperty
  a_adc_rsvd: assert property (p_adc_rsvd) else $error("adc0 reserved bits wrong");
  property p_lock_rd; readStrobe && address == 8'h00 && lockState[0] |=> readData[31]; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock bit not read back");
  property p_lock_set; writeStrobe && address == 8'h00 && writeData[31] |-> ##2 lockState[0];
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set by write");
  property p_sticky; lockState != 3'h0 |=> (lockState & $past(lockState)) == $past(lockState);
  endproperty
  a_sticky: assert property (p_sticky) else $error("lock cleared without reset");
endmodule
bind trigger_source_select_regs trigger_source_select_regs_monitor u_mon (.clock(clock),
  .srst(srst), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .extTriggerOut(extTriggerOut),
  .adc0RoutineTrigger(adc0RoutineTrigger), .lockState(lockState));
`default_nettype wire

// [tb/trigger_source_select_regs_tb_top.sv]
// self-checking bench for the trigger selector registers
`timescale 1ns/1ps
`default_nettype none
module trigger_source_select_regs_tb_top;
  logic clock = 0, srst = 1, writeStrobe = 0, readStrobe = 0, rdSeen = 0, adc0RoutineTrigger;
  logic [7:0] address = 8'h00, extTriggerOut;
  logic [31:0] writeData = 32'h0, readData, seed = 32'h9732;
  logic [125:0] triggerSources = '0;
  logic [127:0] src;
  logic [63:0] f;
  logic [2:0] lockState;
  logic [31:0] expQ[$];
  int nErrors = 0, nTests = 0;
  trigger_source_select_regs u_trigger_source_select_regs (.clock(clock), .srst(srst),
    .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .triggerSources(triggerSources),
    .extTriggerOut(extTriggerOut), .adc0RoutineTrigger(adc0RoutineTrigger),
    .lockState(lockState));
  always #25 clock = ~clock;
  function automatic logic [31:0] nr();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  function automatic logic route(input logic [6:0] c, input logic [125:0] s);
    return (c == 7'h00) ? 1'b0 : (c == 7'h01) ? 1'b1 : s[c - 7'h02];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobes are left up so back-to-back calls never assign them twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    readStrobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    address <= a;
    readStrobe <= 1'b1;
    writeStrobe <= 1'b0;
    expQ.push_back(e);
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    writeStrobe <= 1'b0;
    readStrobe <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rdSeen) chk("readData", readData, expQ.pop_front());
    rdSeen <= readStrobe;
  end
  task automatic wrap_up;
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    nErrors++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h00001E16);
    rd(8'h0C, 32'h0);
    rd(8'h02, 32'h0);
    triggerSources <= 126'h1 << 20;
    idle(3);
    chk("adcReset", adc0RoutineTrigger, triggerSources[20]);
    chk("extReset", extTriggerOut, 8'h00);
    for (int i = 0; i < 8; i++) begin
      f = {nr(), nr()} & 64'h7F7F7F7F7F7F7F7F;
      if (i == 0) f[23:0] = 24'h7F0100;
      src = {nr(), nr(), nr(), nr()};
      triggerSources <= src[125:0];
      wr(8'h00, f[31:0]);
      wr(8'h04, f[63:32]);
      wr(8'h08, {25'h3C, f[38:32]});
      rd(8'h00, f[31:0]);
      rd(8'h04, f[63:32]);
      rd(8'h08, {25'h3C, f[38:32]});
      idle(3);
      for (int k = 0; k < 8; k++) begin
        chk("ext", extTriggerOut[k], route(f[k*8 +: 7], triggerSources));
      end
      chk("adc", adc0RoutineTrigger, route(f[38:32], triggerSources));
    end
    wr(8'h00, 32'h80000302);
    wr(8'h00, 32'h00000505);
    wr(8'h04, 32'h80000000);
    wr(8'h08, 32'h80001E03);
    wr(8'h08, 32'h00001E16);
    wr(8'h0C, 32'h00000000);
    rd(8'h00, 32'h80000302);
    rd(8'h04, 32'h80000000);
    rd(8'h08, 32'h80001E03);
    idle(2);
    chk("lockState", lockState, 3'h7);
    chk("lockedOut0", extTriggerOut[0], route(7'h02, triggerSources));
    chk("lockedAdc", adc0RoutineTrigger, route(7'h03, triggerSources));
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h00001E16);
    idle(3);
    chk("lockReset", lockState, 3'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
